/* logic/fpbr_ctrl.sv */
// Host controller driving a page/burst NOR flash, with a classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Read-array command before array reads after writes
// - Async reads only while mode bit is one
// - Async read: ADV low, WE and RST high
// - Burst after config needs no read-array
// - Address latched at ADV rise or edge
// - Bursts of eight or sixteen, ended by CE
// - Config written by command, read via identifier
// - Latency codes two to ten only
// - Reserved configuration bits written as zero
// - Burst length codes 010 and 011 only
// - Config is 0x60 then 0x03, value on address
module fpbr_ctrl
   import fpbr_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Flash pins
   output logic [FPBR_AW-1:0] flash_addr_o,
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   output logic flash_rst_n_o,
   output logic address_valid_n_o,
   output logic flash_clk_o,
   input wire logic flash_wait_i,
   input wire logic [15:0] flash_dq_i,
   output logic [15:0] flash_dq_o,
   output logic flash_dq_oe_o
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      fpbr_state_e fsm;
      logic [2:0] op;
      logic ph;
      logic [3:0] tmr;
      logic [4:0] cnt;
      logic hold;
      logic wait_prev;
      logic [FPBR_AW-1:0] sw_addr;
      logic [15:0] wdata;
      logic [15:0] cfg;
      logic [15:0] rdata;
      logic [15:0][15:0] bbuf;
      logic need_ra;
      logic pg_ok;
      logic [FPBR_AW-4:0] pg_tag;
      logic err;
      logic ack;
      logic [31:0] dat;
      logic [FPBR_AW-1:0] fa;
      logic [15:0] dq;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic adv_n;
      logic rst_n;
      logic clk_en;
   } fpbr_ctrl_s;

   fpbr_ctrl_s st;
   fpbr_ctrl_s next_st;

   logic clk_valid;
   logic clk_sample;
   logic busy;
   logic hit;
   logic wact;
   logic weff;
   logic [3:0] lc;
   logic [2:0] bl;
   logic [4:0] blen;
   logic [15:0] cfg_val;
   logic cfg_bad;

   // ****************************************
   // Burst clock
   // ****************************************
   fpbr_clkgen u_clkgen (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .en_i(st.clk_en),
      .rising_i(st.cfg[FPBR_CE_BIT]),
      .flash_clk_o(flash_clk_o),
      .valid_o(clk_valid),
      .sample_o(clk_sample)
   );

   // Decoded configuration and helper terms
   always_comb begin
      busy = (st.fsm != FPBR_IDLE);
      lc = st.cfg[FPBR_LC_LSB +: 4];
      bl = st.cfg[2:0];
      blen = (bl == FPBR_BL_16) ? FPBR_LEN_16 : FPBR_LEN_8;
      // Wait is read at its programmed active level
      wact = st.cfg[FPBR_WP_BIT] ? flash_wait_i : ~flash_wait_i;
      // With early deassertion the wait seen one clock before the word counts
      weff = st.cfg[FPBR_WD_BIT] ? st.wait_prev : wact;
      // Page stays usable only while CE has been held low since sensing
      hit = st.pg_ok & ~st.ce_n & (st.sw_addr[FPBR_AW-1:3] == st.pg_tag);
      // Reserved bits forced clear, order bit forced to linear
      cfg_val = (st.wdata & ~FPBR_CFG_RSV_MASK) | (16'h0001 << FPBR_BS_BIT);
      cfg_bad = (cfg_val[FPBR_LC_LSB +: 4] < FPBR_LC_MIN)
         || (cfg_val[FPBR_LC_LSB +: 4] > FPBR_LC_MAX)
         || ((cfg_val[2:0] != FPBR_BL_8) && (cfg_val[2:0] != FPBR_BL_16));
   end

   // ****************************************
   // Register access and sequencer
   // ****************************************
   // One pass builds the next state; bus writes, launches and pin phases
   always_comb begin
      next_st = st;
      next_st.rst_n = 1'b1;
      next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
      // Bus access is served as ack rises
      if (next_st.ack) begin
         next_st.dat = 32'h0000_0000;
         if (wb_adr_i[FPBR_BUF_BIT]) begin
            next_st.dat = {16'h0000, st.bbuf[wb_adr_i[5:2]]};
         end else begin
            case (wb_adr_i)
               FPBR_OFF_ADDR: next_st.dat = {8'h00, st.sw_addr};
               FPBR_OFF_WDATA: next_st.dat = {16'h0000, st.wdata};
               FPBR_OFF_STATUS: next_st.dat = {19'h0, st.cnt, 4'h0, st.pg_ok, st.need_ra,
                  st.err, busy};
               FPBR_OFF_CONFIG: next_st.dat = {16'h0000, st.cfg};
               FPBR_OFF_RDATA: next_st.dat = {16'h0000, st.rdata};
               default: next_st.dat = 32'h0000_0000;
            endcase
         end
         if (wb_we_i) begin
            case (wb_adr_i)
               FPBR_OFF_ADDR: begin
                  if (wb_sel_i[0]) next_st.sw_addr[7:0] = wb_dat_i[7:0];
                  if (wb_sel_i[1]) next_st.sw_addr[15:8] = wb_dat_i[15:8];
                  if (wb_sel_i[2]) next_st.sw_addr[23:16] = wb_dat_i[23:16];
               end
               FPBR_OFF_WDATA: begin
                  if (wb_sel_i[0]) next_st.wdata[7:0] = wb_dat_i[7:0];
                  if (wb_sel_i[1]) next_st.wdata[15:8] = wb_dat_i[15:8];
               end
               FPBR_OFF_CMD: begin
                  if (wb_sel_i[0] && busy) begin
                     // A command while busy is dropped and flagged
                     next_st.err = 1'b1;
                  end else if (wb_sel_i[0]) begin
                     next_st.err = 1'b0;
                     next_st.op = wb_dat_i[2:0];
                     next_st.ph = 1'b0;
                     next_st.fa = st.sw_addr;
                     next_st.tmr = 4'(FPBR_WP_CYC);
                     case (wb_dat_i[2:0])
                        FPBR_OP_CMD: begin
                           next_st.dq = st.wdata;
                           next_st.pg_ok = 1'b0;
                           next_st.fsm = FPBR_WR_PULSE;
                        end
                        FPBR_OP_CFG: begin
                           if (cfg_bad) begin
                              next_st.err = 1'b1;
                           end else begin
                              // Value travels on the low address lines
                              next_st.fa = {8'h00, cfg_val};
                              next_st.dq = FPBR_DEV_CFG_SETUP;
                              next_st.pg_ok = 1'b0;
                              next_st.fsm = FPBR_WR_PULSE;
                           end
                        end
                        FPBR_OP_ARD, FPBR_OP_RRD: begin
                           if (!st.cfg[FPBR_RM_BIT]) begin
                              next_st.err = 1'b1;
                           end else if (wb_dat_i[2:0] == FPBR_OP_ARD && st.need_ra) begin
                              next_st.dq = FPBR_DEV_READ_ARRAY;
                              next_st.pg_ok = 1'b0;
                              next_st.fsm = FPBR_WR_PULSE;
                           end else if (wb_dat_i[2:0] == FPBR_OP_ARD && hit) begin
                              // Only the low word bits move: page buffer serves it
                              next_st.tmr = 4'(FPBR_PAGE_CYC);
                              next_st.fsm = FPBR_RD_WAIT;
                           end else begin
                              next_st.fsm = FPBR_RD_CEOFF;
                           end
                        end
                        FPBR_OP_BRD, FPBR_OP_RBR: begin
                           next_st.pg_ok = 1'b0;
                           if (st.cfg[FPBR_RM_BIT] || (bl != FPBR_BL_8 && bl != FPBR_BL_16)) begin
                              next_st.err = 1'b1;
                           end else if (wb_dat_i[2:0] == FPBR_OP_BRD && st.need_ra) begin
                              next_st.dq = FPBR_DEV_READ_ARRAY;
                              next_st.fsm = FPBR_WR_PULSE;
                           end else begin
                              next_st.fsm = FPBR_RD_CEOFF;
                           end
                        end
                        default: next_st.err = 1'b1;
                     endcase
                  end
               end
               default: ;
            endcase
         end
      end
      // Pin phases
      case (st.fsm)
         FPBR_IDLE: begin
            next_st.oe_n = 1'b1;
            next_st.we_n = 1'b1;
            next_st.dq_oe = 1'b0;
         end
         FPBR_WR_PULSE: begin
            next_st.ce_n = 1'b0;
            next_st.we_n = 1'b0;
            next_st.oe_n = 1'b1;
            next_st.adv_n = 1'b0;
            next_st.dq_oe = 1'b1;
            next_st.tmr = st.tmr - 4'h1;
            if (st.tmr == 4'h0) begin
               next_st.tmr = 4'(FPBR_WP_CYC);
               next_st.fsm = FPBR_WR_GAP;
            end
         end
         FPBR_WR_GAP: begin
            next_st.ce_n = 1'b1;
            next_st.we_n = 1'b1;
            next_st.dq_oe = 1'b0;
            next_st.tmr = st.tmr - 4'h1;
            if (st.tmr == 4'h0) begin
               next_st.tmr = 4'(FPBR_WP_CYC);
               case (st.op)
                  FPBR_OP_CMD: begin
                     // Anything but read-array leaves the array unreadable
                     next_st.need_ra = (st.dq != FPBR_DEV_READ_ARRAY);
                     next_st.fsm = FPBR_IDLE;
                  end
                  FPBR_OP_CFG: begin
                     if (!st.ph) begin
                        next_st.ph = 1'b1;
                        next_st.dq = FPBR_DEV_CFG_CONFIRM;
                        next_st.fsm = FPBR_WR_PULSE;
                     end else begin
                        next_st.cfg = st.fa[15:0];
                        next_st.need_ra = 1'b0;
                        next_st.fsm = FPBR_IDLE;
                     end
                  end
                  default: begin
                     next_st.need_ra = 1'b0;
                     next_st.fa = st.sw_addr;
                     next_st.fsm = FPBR_RD_CEOFF;
                  end
               endcase
            end
         end
         FPBR_RD_CEOFF: begin
            // One cycle of CE high forces the device to sense afresh
            next_st.ce_n = 1'b1;
            next_st.oe_n = 1'b1;
            next_st.tmr = 4'(FPBR_INIT_CYC);
            if (st.op == FPBR_OP_BRD || st.op == FPBR_OP_RBR) begin
               next_st.clk_en = 1'b1;
               next_st.fsm = FPBR_BU_ADV;
            end else begin
               next_st.fsm = FPBR_RD_WAIT;
            end
         end
         FPBR_RD_WAIT: begin
            next_st.ce_n = 1'b0;
            next_st.oe_n = 1'b0;
            next_st.we_n = 1'b1;
            next_st.adv_n = 1'b0;
            next_st.tmr = st.tmr - 4'h1;
            if (st.tmr == 4'h0) begin
               next_st.rdata = flash_dq_i;
               next_st.oe_n = 1'b1;
               next_st.fsm = FPBR_IDLE;
               if (st.op == FPBR_OP_ARD) begin
                  // CE stays low so the sensed group remains in the buffer
                  next_st.pg_ok = 1'b1;
                  next_st.pg_tag = st.fa[FPBR_AW-1:3];
               end else begin
                  // Register data is a single word: no page to reuse
                  next_st.ce_n = 1'b1;
                  next_st.pg_ok = 1'b0;
               end
            end
         end
         FPBR_BU_ADV: begin
            next_st.ce_n = 1'b0;
            next_st.oe_n = 1'b0;
            next_st.adv_n = 1'b0;
            next_st.cnt = 5'h00;
            next_st.hold = 1'b0;
            next_st.wait_prev = 1'b0;
            // Device takes the address on this edge with ADV low
            if (clk_valid) begin
               next_st.adv_n = 1'b1;
               next_st.tmr = 4'h0;
               next_st.fsm = FPBR_BU_LAT;
            end
         end
         FPBR_BU_LAT: begin
            if (clk_valid) begin
               next_st.tmr = st.tmr + 4'h1;
               if (st.tmr + 4'h1 == lc) begin
                  next_st.fsm = FPBR_BU_DATA;
               end
            end
         end
         FPBR_BU_DATA: begin
            if (clk_sample) begin
               next_st.wait_prev = wact;
               if (!weff && !st.hold) begin
                  next_st.bbuf[st.cnt[3:0]] = flash_dq_i;
                  if (st.cnt == 5'h00) next_st.rdata = flash_dq_i;
                  next_st.cnt = st.cnt + 5'h01;
                  next_st.hold = st.cfg[FPBR_DH_BIT];
                  // Register reads stop after their one held word
                  if (st.cnt + 5'h01 == ((st.op == FPBR_OP_RBR) ? FPBR_LEN_REG : blen)) begin
                     next_st.ce_n = 1'b1;
                     next_st.oe_n = 1'b1;
                     next_st.clk_en = 1'b0;
                     next_st.fsm = FPBR_IDLE;
                  end
               end else if (!weff) begin
                  next_st.hold = 1'b0;
               end
            end
         end
         default: next_st.fsm = FPBR_IDLE;
      endcase
   end

   // State register; the shadow starts in asynchronous page mode
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '0;
         st.fsm <= FPBR_IDLE;
         st.cfg <= FPBR_CFG_RESET;
         st.ce_n <= 1'b1;
         st.oe_n <= 1'b1;
         st.we_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign wb_dat_o = st.dat;
   assign wb_ack_o = st.ack;
   assign flash_addr_o = st.fa;
   assign flash_ce_n_o = st.ce_n;
   assign flash_oe_n_o = st.oe_n;
   assign flash_we_n_o = st.we_n;
   assign flash_rst_n_o = st.rst_n;
   assign address_valid_n_o = st.adv_n;
   assign flash_dq_o = st.dq;
   assign flash_dq_oe_o = st.dq_oe;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking a_clk @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_async_pins: assert property ((st.fsm == FPBR_RD_WAIT) ##1 (st.fsm == FPBR_RD_WAIT)
      |-> !address_valid_n_o && !flash_ce_n_o && flash_we_n_o && flash_rst_n_o)
      else $error("async read pins wrong");
   a_async_clk_high: assert property (!st.clk_en ##1 !st.clk_en |-> flash_clk_o)
      else $error("flash clock not high outside bursts");
   a_async_mode: assert property ((st.fsm == FPBR_RD_WAIT) |-> st.cfg[FPBR_RM_BIT])
      else $error("async read in burst mode");
   a_cfg_order: assert property ((st.fsm == FPBR_WR_PULSE) && (st.op == FPBR_OP_CFG)
      |-> (st.dq == (st.ph ? FPBR_DEV_CFG_CONFIRM : FPBR_DEV_CFG_SETUP))
      && (st.fa[FPBR_AW-1:16] == 8'h00))
      else $error("config sequence data wrong");
   a_cfg_fields: assert property ((st.op == FPBR_OP_CFG) && (st.fsm == FPBR_WR_PULSE)
      |-> (st.fa[5:3] == 3'h0) && st.fa[FPBR_BS_BIT])
      else $error("config reserved bits not cleared");
   a_burst_latency: assert property ((st.fsm == FPBR_BU_LAT) && clk_valid && (st.tmr + 4'h1 == lc)
      |=> (st.fsm == FPBR_BU_DATA) && (lc >= FPBR_LC_MIN) && (lc <= FPBR_LC_MAX))
      else $error("burst latency wrong");
   a_burst_len: assert property ((st.fsm == FPBR_BU_DATA) |-> (st.cnt < blen))
      else $error("burst ran past its length");
   a_burst_end: assert property ($fell(st.clk_en) |-> flash_ce_n_o && flash_oe_n_o)
      else $error("burst end left chip selected");
   a_adv_release: assert property ((st.fsm == FPBR_BU_ADV) && clk_valid
      |=> address_valid_n_o [*2])
      else $error("address valid not released after latch");

endmodule
`default_nettype wire

/* logic/fpbr_pkg.sv */
// Package: register map, command codes, configuration fields and timing of the flash read host
package fpbr_pkg;

   // ****************************************
   // Clock and access timing
   // ****************************************
   localparam int FPBR_CLK_MHZ = 20;
   localparam int FPBR_T_INIT_NS = 120;
   localparam int FPBR_T_PAGE_NS = 30;
   localparam int FPBR_T_WP_NS = 60;
   // Least times, rounded up to whole cycles
   localparam int FPBR_INIT_CYC = (FPBR_T_INIT_NS * FPBR_CLK_MHZ + 999) / 1000;
   localparam int FPBR_PAGE_CYC = (FPBR_T_PAGE_NS * FPBR_CLK_MHZ + 999) / 1000;
   localparam int FPBR_WP_CYC = (FPBR_T_WP_NS * FPBR_CLK_MHZ + 999) / 1000;

   // ****************************************
   // Software register map (byte offsets)
   // ****************************************
   localparam logic [7:0] FPBR_OFF_CMD = 8'h00;
   localparam logic [7:0] FPBR_OFF_ADDR = 8'h04;
   localparam logic [7:0] FPBR_OFF_WDATA = 8'h08;
   localparam logic [7:0] FPBR_OFF_STATUS = 8'h0C;
   localparam logic [7:0] FPBR_OFF_CONFIG = 8'h10;
   localparam logic [7:0] FPBR_OFF_RDATA = 8'h14;
   localparam int FPBR_BUF_BIT = 6;
   localparam int FPBR_AW = 24;

   // ****************************************
   // Operation codes written to the command register
   // ****************************************
   localparam logic [2:0] FPBR_OP_CMD = 3'h1;
   localparam logic [2:0] FPBR_OP_ARD = 3'h2;
   localparam logic [2:0] FPBR_OP_BRD = 3'h3;
   localparam logic [2:0] FPBR_OP_CFG = 3'h4;
   localparam logic [2:0] FPBR_OP_RRD = 3'h5;
   localparam logic [2:0] FPBR_OP_RBR = 3'h6;

   // ****************************************
   // Device command bytes
   // ****************************************
   localparam logic [15:0] FPBR_DEV_READ_ARRAY = 16'h00FF;
   localparam logic [15:0] FPBR_DEV_CFG_SETUP = 16'h0060;
   localparam logic [15:0] FPBR_DEV_CFG_CONFIRM = 16'h0003;

   // ****************************************
   // Read configuration fields
   // ****************************************
   localparam logic [15:0] FPBR_CFG_RESET = 16'hFFFF;
   localparam logic [15:0] FPBR_CFG_RSV_MASK = 16'h0038;
   localparam int FPBR_RM_BIT = 15;
   localparam int FPBR_LC_LSB = 11;
   localparam int FPBR_WP_BIT = 10;
   localparam int FPBR_DH_BIT = 9;
   localparam int FPBR_WD_BIT = 8;
   localparam int FPBR_BS_BIT = 7;
   localparam int FPBR_CE_BIT = 6;
   localparam logic [3:0] FPBR_LC_MIN = 4'h2;
   localparam logic [3:0] FPBR_LC_MAX = 4'hA;
   localparam logic [2:0] FPBR_BL_8 = 3'h2;
   localparam logic [2:0] FPBR_BL_16 = 3'h3;
   localparam logic [4:0] FPBR_LEN_8 = 5'h08;
   localparam logic [4:0] FPBR_LEN_16 = 5'h10;
   localparam logic [4:0] FPBR_LEN_REG = 5'h01;

   // ****************************************
   // Sequencer states, Gray-coded in declaration order; some jumps (idle entry and exit, burst start) flip two bits
   // ****************************************
   typedef enum logic [2:0] {
      FPBR_IDLE = 3'h0,
      FPBR_WR_PULSE = 3'h1,
      FPBR_WR_GAP = 3'h3,
      FPBR_RD_CEOFF = 3'h2,
      FPBR_RD_WAIT = 3'h6,
      FPBR_BU_ADV = 3'h7,
      FPBR_BU_LAT = 3'h5,
      FPBR_BU_DATA = 3'h4
   } fpbr_state_e;

endpackage

/* logic/fpbr_clkgen.sv */
// Burst clock divider: drives the flash clock and marks its valid and sampling edges
`timescale 1ns/1ps
`default_nettype none
module fpbr_clkgen
   import fpbr_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Control
   input wire logic en_i,
   input wire logic rising_i,
   // Outputs
   output logic flash_clk_o,
   output logic valid_o,
   output logic sample_o
);

   typedef struct packed {
      logic clk;
      logic valid;
      logic sample;
   } fpbr_clkgen_s;

   fpbr_clkgen_s st;
   fpbr_clkgen_s next_st;

   // Half the system rate; the clock rests high outside bursts so that
   // asynchronous reads see a steady high level
   always_comb begin
      next_st = st;
      next_st.clk = en_i ? ~st.clk : 1'b1;
      next_st.valid = en_i & ((~st.clk) == rising_i);
      next_st.sample = en_i & ((~st.clk) != rising_i);
   end

   // State register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '{clk: 1'b1, valid: 1'b0, sample: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign flash_clk_o = st.clk;
   assign valid_o = st.valid;
   assign sample_o = st.sample;

endmodule
`default_nettype wire

/* sim/fpbr_flash_model.sv */
// Behavioural flash device model: page reads, burst reads and read configuration
`timescale 1ns/1ps
`default_nettype none
module fpbr_flash_model
(
   // Host-driven pins
   input wire logic [23:0] addr_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic rst_n_i,
   input wire logic adv_n_i,
   input wire logic clk_i,
   input wire logic [15:0] dq_i,
   // Device-driven pins
   output logic wait_o,
   output logic [15:0] dq_o
);
   logic [15:0] read_configuration;
   logic [15:0] prev;
   logic [15:0] val;
   logic [15:0] last = 16'h0000;
   logic array_mode;
   logic [23:0] lat;
   int e;
   int idx;
   logic wr_strobe_n;
   logic edge_clk;
   // Commands land on whichever of WE and CE rises first; the host lifts both at once
   assign wr_strobe_n = we_n_i | ce_n_i;
   always @(posedge wr_strobe_n or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_configuration <= 16'hFFFF;
         array_mode <= 1'b1;
         prev <= 16'h0000;
      end else begin
         if (prev == 16'h0060 && dq_i == 16'h0003) begin
            read_configuration <= addr_i[15:0];
         end
         array_mode <= dq_i == 16'h00FF || dq_i == 16'h0003;
         prev <= dq_i;
      end
   end
   // The configured clock edge is turned into a rising one
   assign edge_clk = clk_i ~^ read_configuration[6];
   // Edge count restarts on every deselect, so a stale burst never leaks
   always @(posedge edge_clk or posedge ce_n_i) begin
      if (ce_n_i) begin
         e <= 0;
      end else begin
         if (e == 0 && !adv_n_i) lat <= addr_i;
         e <= e + 1;
      end
   end
   // Word zero starts at the latency-th edge after the latch edge
   assign idx = (e - 1 - int'(read_configuration[14:11]))
      / (read_configuration[9] ? 2 : 1);
   // Async data ignores the clock; burst data steps once from the latch
   always_comb begin
      if (read_configuration[15]) begin
         val = array_mode ? addr_i[15:0] ^ 16'hC3A5 : 16'h0080;
      end else begin
         // Register words stand for the rest of the access, array words step once
         val = array_mode ? (lat[15:0] + 16'(idx)) ^ 16'hC3A5 : 16'h0080;
         // Nothing valid before the latency has run out, so an early sample fails
         if (e <= int'(read_configuration[14:11])) val = ~val;
      end
   end
   // Released bus shows the inverse of the last word, never a stale copy
   always @(val or ce_n_i or oe_n_i) if (!ce_n_i && !oe_n_i) last = val;
   assign dq_o = (ce_n_i || oe_n_i) ? ~last : val;
   assign wait_o = ~read_configuration[10];
endmodule
`default_nettype wire

/* sim/test_flash_page_burst_read.sv */
// Self-checking bench of the flash read host against the device model
`timescale 1ns/1ps
`default_nettype none
module test_flash_page_burst_read;
   import fpbr_pkg::*;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat, q, a, b;
   logic ack, ce_n, oe_n, we_n, rst_n, adv_n, fclk, wt, dq_oe;
   logic [23:0] faddr;
   logic [15:0] dq_to, dq_from;
   logic [31:0] seed = 32'hFB20;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   fpbr_ctrl dut (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .flash_addr_o(faddr), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
      .flash_we_n_o(we_n), .flash_rst_n_o(rst_n), .address_valid_n_o(adv_n),
      .flash_clk_o(fclk), .flash_wait_i(wt), .flash_dq_i(dq_from), .flash_dq_o(dq_to),
      .flash_dq_oe_o(dq_oe));
   fpbr_flash_model flash (.addr_i(faddr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .rst_n_i(rst_n), .adv_n_i(adv_n), .clk_i(fclk), .dq_i(dq_to), .wait_o(wt),
      .dq_o(dq_from));
   initial forever #25 clock_i = ~clock_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] word_at(input logic [31:0] x);
      return {16'h0000, x[15:0] ^ 16'hC3A5};
   endfunction
   task automatic end_of_test();
      if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clock_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      dat <= d;
      do @(posedge clock_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic cmd(input logic [2:0] op);
      wb(1'b1, FPBR_OFF_CMD, {29'h0, op});
      do wb(1'b0, FPBR_OFF_STATUS, 32'h0); while (q[0] !== 1'b0);
   endtask
   task automatic aread(input logic [31:0] x);
      wb(1'b1, FPBR_OFF_ADDR, x);
      cmd(FPBR_OP_ARD);
      wb(1'b0, FPBR_OFF_RDATA, 32'h0);
   endtask
   // Hang guard
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      repeat (10) @(posedge clock_i);
      resetn_i <= 1'b1;
      wb(1'b0, FPBR_OFF_CONFIG, 32'h0);
      chk("config", 32'h0000FFFF, q);
      wb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h0, q);
      for (int i = 0; i < 4; i++) begin
         a = rnd() & 32'h00FFFFFF;
         aread(a);
         chk("array", word_at(a), q);
         b = {a[31:3], 3'(rnd())};
         aread(b);
         chk("page", word_at(b), q);
      end
      wb(1'b1, FPBR_OFF_WDATA, 32'h40);
      cmd(FPBR_OP_CMD);
      cmd(FPBR_OP_RRD);
      wb(1'b0, FPBR_OFF_RDATA, 32'h0);
      chk("register", 32'h80, q);
      aread(a);
      chk("after write", word_at(a), q);
      wb(1'b1, FPBR_OFF_WDATA, 32'h0FC2);
      cmd(FPBR_OP_CFG);
      chk("bad latency", 32'h1, (q >> 1) & 32'h1);
      wb(1'b1, FPBR_OFF_WDATA, 32'h1F7A);
      cmd(FPBR_OP_CFG);
      wb(1'b0, FPBR_OFF_CONFIG, 32'h0);
      chk("config", 32'h00001FC2, q);
      b = a & 32'hFFFFF8;
      wb(1'b1, FPBR_OFF_ADDR, b);
      cmd(FPBR_OP_BRD);
      wb(1'b0, FPBR_OFF_STATUS, 32'h0);
      chk("burst count", 32'h8, (q >> 8) & 32'h1F);
      wb(1'b0, 8'h40, 32'h0);
      chk("burst0", word_at(b), q);
      wb(1'b0, 8'h5C, 32'h0);
      chk("burst7", word_at(b + 7), q);
      wb(1'b1, FPBR_OFF_WDATA, 32'h1DC3);
      cmd(FPBR_OP_CFG);
      cmd(FPBR_OP_BRD);
      wb(1'b0, 8'h7C, 32'h0);
      chk("burst15", word_at(b + 15), q);
      wb(1'b1, FPBR_OFF_WDATA, 32'h70);
      cmd(FPBR_OP_CMD);
      cmd(FPBR_OP_RBR);
      wb(1'b0, FPBR_OFF_RDATA, 32'h0);
      chk("burst register", 32'h80, q);
      aread(a);
      wb(1'b0, FPBR_OFF_STATUS, 32'h0);
      chk("async in burst", 32'h1, (q >> 1) & 32'h1);
      end_of_test();
   end
endmodule
`default_nettype wire
